/* File: core/simsk_regs.svh */
// Register offsets, field positions and reset values of the switch interrupt mask and status bank.
// Assumes it is included by bare name from files that already set the default net type.
`ifndef SIMSK_REGS_SVH
`define SIMSK_REGS_SVH

`define SIMSK_ADDR_MASK        8'h04
`define SIMSK_ADDR_STATUS      8'h05
`define SIMSK_ADDR_CTRL        8'h06

`define SIMSK_MASK_RESET       6'h00
`define SIMSK_MASK_PAD         2'h0
`define SIMSK_FAULT_LSB        3
`define SIMSK_FAULT_MSB        5
`define SIMSK_LIMIT_LSB        0
`define SIMSK_LIMIT_MSB        2
`define SIMSK_RSVD_MSB         7
`define SIMSK_RSVD_LSB         6

`define SIMSK_ST_SEAL          7
`define SIMSK_ST_NVM           6
`define SIMSK_ST_LINE          5
`define SIMSK_ST_BUTTON        4
`define SIMSK_ST_PWR_MSB       3
`define SIMSK_ST_PWR_LSB       2
`define SIMSK_ST_CELL_MSB      1
`define SIMSK_ST_CELL_LSB      0
`define SIMSK_STATUS_RST_MASK  8'hc0

`define SIMSK_CTRL_TRIG        0
`define SIMSK_CTRL_PAD         7'h00
`define SIMSK_RD_NONE          8'h00

`endif

/* File: core/simsk_pkg.sv */
// Types shared by the switch interrupt mask and status bank.
// Assumes nothing beyond a SystemVerilog compiler.
package simsk_pkg;

  typedef enum logic [1:0] {
    pwr_transitional        = 2'h0,
    wait_power_enable_state = 2'h1,
    pwr_active              = 2'h2,
    pwr_suspend             = 2'h3
  } simsk_pwr_state_t;

  typedef enum logic [1:0] {
    cell_absent = 2'h0,
    cell_low    = 2'h1,
    cell_good   = 2'h2,
    cell_ideal  = 2'h3
  } simsk_cell_level_t;

  typedef enum logic {
    meas_idle,
    meas_wait
  } simsk_meas_state_t;

endpackage

/* File: core/simsk_sync.sv */
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes each bit is an independent level or is stable while it is sampled.
`timescale 1ns/1ps
`default_nettype none
module simsk_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

/* File: core/simsk_cell_meas.sv */
// Coin-cell acquisition sequencer: issues a start pulse and captures the level on completion.
// Assumes the analog side raises its done level after a start and holds the level code stable.
`timescale 1ns/1ps
`default_nettype none
`include "simsk_regs.svh"
module simsk_cell_meas (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         start,
  input  wire logic                         done_pin,
  input  wire logic [1:0]                   level_pin,
  output logic                              acq_start,
  output simsk_pkg::simsk_cell_level_t      level,
  output logic                              valid,
  output logic                              busy
);

  logic                            done_s;
  logic [1:0]                      level_s;
  logic                            done_prev_q;
  logic                            done_prev_d;
  simsk_pkg::simsk_meas_state_t    state_q;
  simsk_pkg::simsk_meas_state_t    state_d;
  logic                            acq_q;
  logic                            acq_d;
  simsk_pkg::simsk_cell_level_t    level_q;
  simsk_pkg::simsk_cell_level_t    level_d;
  logic                            valid_q;
  logic                            valid_d;

  simsk_sync #(.W(3)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({done_pin, level_pin}),
    .sync_out ({done_s, level_s})
  );

  // A start during a running acquisition is dropped rather than restarting the analog.
  always_comb begin
    state_d     = state_q;
    acq_d       = 1'b0;
    level_d     = level_q;
    valid_d     = valid_q;
    done_prev_d = done_s;
    case (state_q)
      simsk_pkg::meas_idle: begin
        if (start) begin
          acq_d   = 1'b1;
          state_d = simsk_pkg::meas_wait;
        end
      end
      simsk_pkg::meas_wait: begin
        if (done_s && !done_prev_q) begin
          level_d = simsk_pkg::simsk_cell_level_t'(level_s);
          valid_d = 1'b1;
          state_d = simsk_pkg::meas_idle;
        end
      end
      default: state_d = simsk_pkg::meas_idle;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q     <= simsk_pkg::meas_idle;
      acq_q       <= 1'b0;
      level_q     <= simsk_pkg::cell_absent;
      valid_q     <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      acq_q       <= acq_d;
      level_q     <= level_d;
      valid_q     <= valid_d;
      done_prev_q <= done_prev_d;
    end
  end

  assign acq_start = acq_q;
  assign level     = level_q;
  assign valid     = valid_q;
  assign busy      = (state_q == simsk_pkg::meas_wait);

endmodule
`default_nettype wire

/* File: core/simsk_top.sv */
// Switch interrupt mask register, device status register and acquisition control bit.
// Assumes a decoded register port from the serial bus logic on the same clock, the switch
// fault flags from the flag register logic on the same clock, and raw pins for the rest.
`timescale 1ns/1ps
`default_nettype none
`include "simsk_regs.svh"
module simsk_top (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  output logic                               reg_rvalid,
  input  wire logic [2:0]                    fault_flag,
  input  wire logic [2:0]                    limit_cond_pin,
  input  wire logic                          line_detect_pin,
  input  wire logic                          push_button_pin,
  input  wire logic                          seal_broken_in,
  input  wire logic                          nvm_changed_in,
  input  wire simsk_pkg::simsk_pwr_state_t   pwr_state_in,
  input  wire logic                          cell_done_pin,
  input  wire logic [1:0]                    cell_level_pin,
  output logic                               cell_acq_start,
  output logic                               cell_level_valid,
  output logic      [2:0]                    limit_flag,
  output logic                               irq_out_low
);

  logic [2:0]                    limit_s;
  logic                          line_s;
  logic                          button_s;
  logic [5:0]                    mask_q;
  logic [5:0]                    mask_d;
  logic                          trig_q;
  logic                          trig_d;
  logic [2:0]                    limit_flag_q;
  logic [2:0]                    limit_flag_d;
  logic                          fresh_seal_broken_q;
  logic                          fresh_seal_broken_d;
  logic                          nvm_changed_q;
  logic                          nvm_changed_d;
  logic                          line_detect_level_q;
  logic                          line_detect_level_d;
  logic                          button_level_q;
  logic                          button_level_d;
  simsk_pkg::simsk_pwr_state_t   pwr_q;
  simsk_pkg::simsk_pwr_state_t   pwr_d;
  logic [7:0]                    rdata_q;
  logic [7:0]                    rdata_d;
  logic                          rvalid_q;
  logic                          rvalid_d;
  logic                          irq_low_q;
  logic                          irq_low_d;
  logic [5:0]                    event_vec;
  logic [5:0]                    pending;
  logic [7:0]                    status_img;
  logic [7:0]                    mask_img;
  logic [7:0]                    ctrl_img;
  logic                          wr_mask;
  logic                          wr_ctrl;
  simsk_pkg::simsk_cell_level_t  cell_charge_level;
  logic                          meas_busy;

  // Pins from the analog side are brought onto the clock before anything reads them.
  simsk_sync #(.W(5)) u_pin_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({limit_cond_pin, line_detect_pin, push_button_pin}),
    .sync_out ({limit_s, line_s, button_s})
  );

  simsk_cell_meas u_cell (
    .clock     (clock),
    .rst       (rst),
    .start     (trig_q),
    .done_pin  (cell_done_pin),
    .level_pin (cell_level_pin),
    .acq_start (cell_acq_start),
    .level     (cell_charge_level),
    .valid     (cell_level_valid),
    .busy      (meas_busy)
  );

  assign wr_mask = reg_wr && (reg_addr == `SIMSK_ADDR_MASK);
  assign wr_ctrl = reg_wr && (reg_addr == `SIMSK_ADDR_CTRL);

  // Event vector lines up bit for bit with the mask register layout.
  assign event_vec[`SIMSK_FAULT_MSB:`SIMSK_FAULT_LSB] = fault_flag;
  assign event_vec[`SIMSK_LIMIT_MSB:`SIMSK_LIMIT_LSB] = limit_flag_q;

  // Each event reaches the interrupt path only through its own mask bit.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_gate
      assign pending[gi] = event_vec[gi] && !mask_q[gi];
    end
  endgenerate

  assign mask_img   = {`SIMSK_MASK_PAD, mask_q};
  assign ctrl_img   = {`SIMSK_CTRL_PAD, trig_q};
  assign status_img = {fresh_seal_broken_q, nvm_changed_q, line_detect_level_q,
                       button_level_q, pwr_q, cell_charge_level};

  // Register writes, status capture and interrupt output.
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = reg_wdata[`SIMSK_FAULT_MSB:`SIMSK_LIMIT_LSB];
    end
    // The trigger bit lives one cycle; a write while it is high keeps it high one more cycle.
    trig_d = wr_ctrl && reg_wdata[`SIMSK_CTRL_TRIG];
    // Limit flags follow the live condition and never look at the mask.
    limit_flag_d        = limit_s;
    fresh_seal_broken_d = seal_broken_in;
    nvm_changed_d       = nvm_changed_in;
    line_detect_level_d = !line_s;
    button_level_d      = !button_s;
    pwr_d               = pwr_state_in;
    irq_low_d           = !(|pending);
  end

  // Read port; the status offset is read-only, so a write there has no target.
  always_comb begin
    rvalid_d = reg_rd;
    rdata_d  = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `SIMSK_ADDR_MASK:   rdata_d = mask_img;
        `SIMSK_ADDR_STATUS: rdata_d = status_img;
        `SIMSK_ADDR_CTRL:   rdata_d = ctrl_img;
        default:            rdata_d = `SIMSK_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mask_q              <= `SIMSK_MASK_RESET;
      trig_q              <= 1'b0;
      limit_flag_q        <= 3'h0;
      fresh_seal_broken_q <= 1'b0;
      nvm_changed_q       <= 1'b0;
      line_detect_level_q <= 1'b0;
      button_level_q      <= 1'b0;
      pwr_q               <= simsk_pkg::pwr_transitional;
      rdata_q             <= `SIMSK_RD_NONE;
      rvalid_q            <= 1'b0;
      irq_low_q           <= 1'b1;
    end else begin
      mask_q              <= mask_d;
      trig_q              <= trig_d;
      limit_flag_q        <= limit_flag_d;
      fresh_seal_broken_q <= fresh_seal_broken_d;
      nvm_changed_q       <= nvm_changed_d;
      line_detect_level_q <= line_detect_level_d;
      button_level_q      <= button_level_d;
      pwr_q               <= pwr_d;
      rdata_q             <= rdata_d;
      rvalid_q            <= rvalid_d;
      irq_low_q           <= irq_low_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign limit_flag = limit_flag_q;
  assign irq_out_low = irq_low_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence rd_status_s;
    reg_rd && (reg_addr == `SIMSK_ADDR_STATUS);
  endsequence

  sequence rd_mask_s;
    reg_rd && (reg_addr == `SIMSK_ADDR_MASK);
  endsequence

  sequence trig_pulse_s;
    trig_q ##1 !trig_q;
  endsequence

  // Two sampled cycles of an unmasked event; the output answers one cycle behind each.
  sequence pend_held_s;
    (|pending) ##1 (|pending);
  endsequence

  mask_reserved_a : assert property (
    rd_mask_s |=> (reg_rdata[`SIMSK_RSVD_MSB:`SIMSK_RSVD_LSB] == 2'h0)
                  && (reg_rdata[`SIMSK_FAULT_MSB:`SIMSK_LIMIT_LSB] == $past(mask_q)))
    else $error("Mask readback wrong or reserved bits set.");

  mask_reset_a : assert property (@(posedge clock)
    $past(rst) |-> (mask_q == `SIMSK_MASK_RESET) && irq_out_low)
    else $error("Mask not cleared or interrupt asserted after reset.");

  mask_write_a : assert property (
    wr_mask |=> mask_q == $past(reg_wdata[`SIMSK_FAULT_MSB:`SIMSK_LIMIT_LSB]))
    else $error("Mask write did not land.");

  irq_unmasked_a : assert property (
    (|(event_vec & ~mask_q)) |=> !irq_out_low)
    else $error("Unmasked event failed to pull the interrupt low.");

  irq_masked_a : assert property (
    ((event_vec & ~mask_q) == 6'h00) |=> irq_out_low)
    else $error("Interrupt low with no unmasked event.");

  irq_hold_a : assert property (
    pend_held_s |-> !irq_out_low ##1 !irq_out_low)
    else $error("Interrupt released while an unmasked event persists.");

  monitor_free_a : assert property (
    (mask_q[`SIMSK_LIMIT_MSB:`SIMSK_LIMIT_LSB] != 3'h0) |=> limit_flag == $past(limit_s))
    else $error("Limit monitoring disturbed by masking.");

  status_rdonly_a : assert property (
    (reg_wr && (reg_addr == `SIMSK_ADDR_STATUS)) |=> $stable(mask_q) && !trig_q)
    else $error("Write to status altered other state.");

  status_reset_a : assert property (@(posedge clock)
    $past(rst) |-> ((status_img & `SIMSK_STATUS_RST_MASK) == 8'h00))
    else $error("Status top bits not zero after reset.");

  seal_bit_a : assert property (
    rd_status_s |=> reg_rdata[`SIMSK_ST_SEAL] == $past(fresh_seal_broken_q))
    else $error("Seal bit does not match seal state.");

  nvm_bit_a : assert property (
    rd_status_s |=> reg_rdata[`SIMSK_ST_NVM] == $past(nvm_changed_q))
    else $error("Settings-changed bit mismatched.");

  line_level_a : assert property (
    rd_status_s |=> reg_rdata[`SIMSK_ST_LINE] == !$past(line_s, 2))
    else $error("Line-detect bit not the inverse of the pin.");

  button_level_a : assert property (
    rd_status_s |=> reg_rdata[`SIMSK_ST_BUTTON] == !$past(button_s, 2))
    else $error("Push-button bit not the inverse of the pin.");

  pwr_field_a : assert property (
    rd_status_s |=> reg_rdata[`SIMSK_ST_PWR_MSB:`SIMSK_ST_PWR_LSB] == $past(pwr_state_in, 2))
    else $error("Power state field mismatched.");

  cell_field_a : assert property (
    rd_status_s |=> reg_rdata[`SIMSK_ST_CELL_MSB:`SIMSK_ST_CELL_LSB] == $past(cell_charge_level))
    else $error("Cell level field mismatched.");

  trig_clear_a : assert property (
    (wr_ctrl && reg_wdata[`SIMSK_CTRL_TRIG] && !trig_q) |=> trig_pulse_s)
    else $error("Acquisition bit did not clear itself.");

  trig_start_a : assert property (
    (trig_q && !meas_busy) |=> cell_acq_start)
    else $error("Acquisition not started by the trigger bit.");

  limit_follow_a : assert property (
    $changed(limit_s) |=> limit_flag == $past(limit_s))
    else $error("Limit flag does not follow the live condition.");

endmodule
`default_nettype wire

/* File: tb/simsk_cell_model.sv */
// Behavioural coin-cell converter that answers acquisition start pulses.
// Assumes start pulses arrive on the bench clock and code is set before a start.
`timescale 1ns/1ps
`default_nettype none
module simsk_cell_model (
  input  wire logic       clock,
  input  wire logic       acq_start,
  input  wire logic       slow,
  input  wire logic [1:0] code,
  output logic            done_pin,
  output logic      [1:0] level_pin
);
  // The code is held well past done rising because the design only sees done
  // after its synchronisers; once done drops the lines show the inverse.
  initial begin
    done_pin  = 1'b0;
    level_pin = 2'h0;
    forever begin
      @(posedge clock);
      if (acq_start === 1'b1) begin
        #1;
        level_pin = code;
        repeat (slow ? 12 : 2) @(posedge clock);
        #1;
        done_pin = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        done_pin  = 1'b0;
        level_pin = ~code;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/simsk_top_tb.sv */
// Self-checking bench for the switch interrupt mask and status bank.
// Assumes the design files under core/ and the converter model under tb/.
`timescale 1ns/1ps
`default_nettype none
`include "simsk_regs.svh"
module simsk_top_tb;
  logic                        clock;
  logic                        rst;
  logic [7:0]                  reg_addr;
  logic [7:0]                  reg_wdata;
  logic                        reg_wr;
  logic                        reg_rd;
  logic [7:0]                  reg_rdata;
  logic                        reg_rvalid;
  logic [2:0]                  fault_flag;
  logic [2:0]                  limit_cond_pin;
  logic                        line_detect_pin;
  logic                        push_button_pin;
  logic                        seal_broken_in;
  logic                        nvm_changed_in;
  simsk_pkg::simsk_pwr_state_t pwr_state_in;
  logic                        cell_done_pin;
  logic [1:0]                  cell_level_pin;
  logic                        cell_acq_start;
  logic                        cell_level_valid;
  logic [2:0]                  limit_flag;
  logic                        irq_out_low;
  logic                        cell_slow;
  logic [1:0]                  cell_code;
  logic [5:0]                  ev;
  logic [7:0]                  rd_val;
  int                          errors;
  int                          compares;
  int                          starts;
  int                          n;

  simsk_top dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .fault_flag(fault_flag), .limit_cond_pin(limit_cond_pin),
    .line_detect_pin(line_detect_pin), .push_button_pin(push_button_pin),
    .seal_broken_in(seal_broken_in), .nvm_changed_in(nvm_changed_in),
    .pwr_state_in(pwr_state_in), .cell_done_pin(cell_done_pin),
    .cell_level_pin(cell_level_pin), .cell_acq_start(cell_acq_start),
    .cell_level_valid(cell_level_valid), .limit_flag(limit_flag),
    .irq_out_low(irq_out_low));

  simsk_cell_model partner (.clock(clock), .acq_start(cell_acq_start), .slow(cell_slow),
    .code(cell_code), .done_pin(cell_done_pin), .level_pin(cell_level_pin));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Counting every start pulse also exposes a doubled or missing pulse.
  always @(posedge clock) begin
    if (cell_acq_start === 1'b1) begin
      starts++;
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int cycles);
    repeat (cycles) @(posedge clock);
    #1;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    int k;
    reg_addr = addr;
    reg_rd   = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    k = 0;
    while (reg_rvalid !== 1'b1 && k < 4) begin
      tick(1);
      k++;
    end
    if (reg_rvalid !== 1'b1) begin
      errors++;
      $display("ERROR read answer expected 1 seen %b", reg_rvalid);
      tally_and_finish();
    end
    data = reg_rdata;
    tick(1);
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fault_flag = 3'h0;
    limit_cond_pin = 3'h0;
    line_detect_pin = 1'b1;
    push_button_pin = 1'b1;
    seal_broken_in = 1'b0;
    nvm_changed_in = 1'b0;
    pwr_state_in = simsk_pkg::pwr_transitional;
    cell_slow = 1'b0;
    cell_code = 2'h0;
    errors = 0;
    compares = 0;
    starts = 0;
    tick(3);
    rst = 1'b0;
    tick(4);
    check("irq idle", 8'h01, {7'h00, irq_out_low});
    check("level invalid", 8'h00, {7'h00, cell_level_valid});
    reg_read(`SIMSK_ADDR_MASK, rd_val);
    check("mask reset", 8'h00, rd_val);
    reg_read(`SIMSK_ADDR_STATUS, rd_val);
    check("status reset", 8'h00, rd_val & `SIMSK_STATUS_RST_MASK);
    $display("test reset done");

    reg_write(`SIMSK_ADDR_MASK, 8'hff);
    reg_read(`SIMSK_ADDR_MASK, rd_val);
    check("mask fields", 8'h3f, rd_val);
    reg_write(`SIMSK_ADDR_STATUS, 8'hff);
    reg_read(`SIMSK_ADDR_STATUS, rd_val);
    check("status write", 8'h00, rd_val & `SIMSK_STATUS_RST_MASK);
    reg_read(8'h20, rd_val);
    check("unmapped read", 8'h00, rd_val);
    $display("test access done");

    // Every event is tried alone with all other sources masked.
    for (int i = 0; i < 6; i++) begin
      ev = 6'h01 << i;
      reg_write(`SIMSK_ADDR_MASK, {2'h0, 6'h3f & ~ev});
      fault_flag = ev[5:3];
      limit_cond_pin = ev[2:0];
      tick(6);
      check("irq unmasked", 8'h00, {7'h00, irq_out_low});
      check("limit flag", {5'h00, ev[2:0]}, {5'h00, limit_flag});
      reg_write(`SIMSK_ADDR_MASK, 8'h3f);
      tick(3);
      check("irq masked", 8'h01, {7'h00, irq_out_low});
      check("limit kept", {5'h00, ev[2:0]}, {5'h00, limit_flag});
      reg_write(`SIMSK_ADDR_MASK, 8'h00);
      fault_flag = 3'h0;
      limit_cond_pin = 3'h0;
      tick(6);
      check("irq released", 8'h01, {7'h00, irq_out_low});
    end
    $display("test interrupt done");

    for (int p = 0; p < 4; p++) begin
      pwr_state_in = simsk_pkg::simsk_pwr_state_t'(p[1:0]);
      seal_broken_in = p[0];
      nvm_changed_in = p[1];
      line_detect_pin = p[1];
      push_button_pin = p[0];
      tick(5);
      reg_read(`SIMSK_ADDR_STATUS, rd_val);
      check("status", {p[0], p[1], ~p[1], ~p[0], p[1:0], 2'h0}, rd_val & 8'hfc);
    end
    $display("test status done");

    // The cell bits are read only after an acquisition has completed.
    for (int c = 0; c < 4; c++) begin
      cell_code = c[1:0];
      cell_slow = c[0];
      reg_write(`SIMSK_ADDR_CTRL, 8'h01);
      // A second trigger while the slow acquisition runs must not start another one.
      if (cell_slow) begin
        reg_write(`SIMSK_ADDR_CTRL, 8'h01);
      end
      n = 0;
      while (cell_done_pin !== 1'b1 && n < 40) begin
        tick(1);
        n++;
      end
      if (cell_done_pin !== 1'b1) begin
        errors++;
        $display("ERROR done pin expected 1 seen %b", cell_done_pin);
        tally_and_finish();
      end
      tick(8);
      check("start pulses", 8'(c + 1), 8'(starts));
      check("level valid", 8'h01, {7'h00, cell_level_valid});
      reg_read(`SIMSK_ADDR_CTRL, rd_val);
      check("trigger clear", 8'h00, rd_val);
      reg_read(`SIMSK_ADDR_STATUS, rd_val);
      check("cell level", {6'h00, c[1:0]}, rd_val & 8'h03);
    end
    $display("test acquisition done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
